// >>> logic/vec_defs.vh
// constants for the video encoder control host: offsets, fields, resets and timing
`ifndef VEC_DEFS_VH
`define VEC_DEFS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define VEC_CLK_MHZ 100
// quarter of a serial clock period; four quarters give about 357 kHz
`define VEC_QTR_NS 700
`define VEC_QTR_CYC ((`VEC_QTR_NS * `VEC_CLK_MHZ + 999) / 1000)
// datapath reset hold: over 100 pixel clocks at the slowest 6 MHz pixel clock
`define VEC_RST_HOLD_NS 17000
`define VEC_RST_HOLD_CYC ((`VEC_RST_HOLD_NS * `VEC_CLK_MHZ + 999) / 1000)
// settle time before the converters come back on, more than 30 ms
`define VEC_DAC_WAIT_US 31000
`define VEC_DAC_WAIT_CYC (`VEC_DAC_WAIT_US * `VEC_CLK_MHZ)

// ----------------------------------------------------------------
// own wishbone registers (byte addresses)
// ----------------------------------------------------------------
`define VEC_OFS_CTRL 8'h00
`define VEC_OFS_DATA 8'h04
`define VEC_OFS_CMD 8'h08
`define VEC_OFS_STAT 8'h0C
`define VEC_CTRL_RESET 32'h0000_0000
`define VEC_DATA_RESET 32'h0000_0000

// control register fields
`define VEC_CTRL_ASEL 0
`define VEC_CTRL_PDN 1
`define VEC_CTRL_RD 2
`define VEC_CTRL_CNT_LO 3
`define VEC_CTRL_SUB_LO 8
`define VEC_CTRL_MODE_LO 16
`define VEC_CTRL_OUTPUT_LEVEL_SELECT 18
`define VEC_CTRL_CSEL 19
`define VEC_CTRL_EN_LO 20
`define VEC_CTRL_FMT_LO 24

// command and status fields
`define VEC_CMD_XFER 0
`define VEC_CMD_SWITCH 1
`define VEC_STAT_BUSY 0
`define VEC_STAT_NACK 1
`define VEC_STAT_REFUSED 2
`define VEC_STAT_DONE 3

// ----------------------------------------------------------------
// device side: bus address and register map
// ----------------------------------------------------------------
`define VEC_DEV_ADDR_HI 6'h10
`define VEC_SUB_POWER_DOWN 8'h06
`define VEC_SUB_FORMAT 8'h0B
`define VEC_SUB_DAC 8'h0D
`define VEC_SUB_SPLIT_LO 9'h035
`define VEC_SUB_TEST_BASE 9'h040
`define VEC_PLL_RUN_BIT 2
`define VEC_MODE_COMPOSITE 2'b00
`define VEC_MODE_COMPONENT 2'b01
`define VEC_MODE_DAC 2'b10
`define VEC_MODE_RESERVED 2'b11

`endif

// >>> logic/vec_sync2.v
// two-stage synchroniser for an input from outside the clock domain
`timescale 1ns/10ps
module vec_sync2 #(
   parameter RESET_VAL = 1'b1
) (
   // system
   input wire clk_i,
   input wire srst_i,
   // level in and out
   input wire async_i,
   output reg sync_o
);
   reg meta_q;

   // first stage is read only by the second
   always @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // vec_sync2

// >>> logic/vec_ctrl_host.v
// host-side serial bus controller for a multi-format video encoder
//
// Behaviour
// - write: address with direction 0, one sub-address, then data bytes.
// - read: write sub-address, repeated start, address with direction 1, read.
// - acknowledge is data low on ninth clock; direction 1 reads, 0 writes.
// - no burst crosses sub-address 0x35 to 0x36.
// - test registers only by single-byte transfers.
// - component mode: composite block sleeps; software sets the PLL-run bit.
// - converter mode: both encoders sleep; software keeps PLL-run bit at 0.
// - with composite on first converter, second and third enables are cleared.
// - mode change order: converters off, PLL off, mode, then output setup.
// - mode and output setup are written before any pixel clock change.
// - datapath reset held low over 100 pixel clocks after a mode change.
// - wait over 30 ms after reset release before converters go back on.
`timescale 1ns/10ps
`include "vec_defs.vh"
module vec_ctrl_host #(
   parameter [21:0] DAC_WAIT_CYC = `VEC_DAC_WAIT_CYC
) (
   // system
   input wire CLK_I,
   input wire SRST_I,
   // wishbone slave
   input wire CYC_I,
   input wire STB_I,
   input wire WE_I,
   input wire [7:0] ADR_I,
   input wire [3:0] SEL_I,
   input wire [31:0] DAT_I,
   output reg [31:0] DAT_O,
   output reg ACK_O,
   // serial bus pins, open drain
   input wire SCL_I,
   output reg SCL_O,
   output reg SCL_OE_O,
   input wire SDA_I,
   output reg SDA_O,
   output reg SDA_OE_O,
   // device strap and power pins
   output reg BUS_ADDRESS_SELECT_PIN_O,
   output reg POWER_DOWN_PIN_N_O
);
   // ----------------------------------------------------------------
   // constants and states
   // ----------------------------------------------------------------
   localparam integer QTR_CYC = `VEC_QTR_CYC;
   localparam integer RST_HOLD_CYC = `VEC_RST_HOLD_CYC;
   localparam [6:0] QTR_LAST = QTR_CYC[6:0] - 7'd1;
   localparam [21:0] RST_HOLD_LAST = RST_HOLD_CYC[21:0] - 22'd1;
   localparam [21:0] DAC_WAIT_LAST = DAC_WAIT_CYC - 22'd1;
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_START = 3'd1;
   localparam [2:0] S_BIT = 3'd2;
   localparam [2:0] S_STOP = 3'd3;
   localparam [2:0] S_WAIT = 3'd4;
   localparam [2:0] P_AW = 3'd0;
   localparam [2:0] P_SUB = 3'd1;
   localparam [2:0] P_WD = 3'd2;
   localparam [2:0] P_AR = 3'd3;
   localparam [2:0] P_RD = 3'd4;
   localparam [3:0] SEQ_END = 4'd9;

   reg [31:0] ctrl_q;
   reg [31:0] data_q;
   reg [2:0] state_q;
   reg [2:0] phase_q;
   reg [1:0] qtr_q;
   reg [6:0] tick_q;
   reg [3:0] bit_q;
   reg [7:0] shreg_q;
   reg [1:0] idx_q;
   reg [1:0] cnt_q;
   reg [7:0] sub_q;
   reg rd_q;
   reg nack_seen_q;
   reg seq_act_q;
   reg [3:0] seq_q;
   reg [21:0] wait_q;
   reg ev_nack_q;
   reg ev_done_q;
   reg ev_rd_q;
   reg [1:0] rd_idx_q;
   reg [7:0] rbyte_q;
   reg nack_q;
   reg refused_q;
   reg done_q;
   reg scl_oe_d;
   reg sda_oe_d;
   reg [7:0] seq_sub;
   reg [7:0] seq_data;
   reg [1:0] seq_wait;
   wire scl_s;
   wire sda_s;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   vec_sync2 #(.RESET_VAL(1'b1)) u_sync_scl (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .async_i(SCL_I),
      .sync_o(scl_s)
   );

   vec_sync2 #(.RESET_VAL(1'b1)) u_sync_sda (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .async_i(SDA_I),
      .sync_o(sda_s)
   );

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   wire wb_hit = CYC_I & STB_I & ~ACK_O;
   wire wb_wr = wb_hit & WE_I;
   wire [31:0] wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
   wire wr_ctrl = wb_wr & (ADR_I == `VEC_OFS_CTRL);
   wire wr_data = wb_wr & (ADR_I == `VEC_OFS_DATA);
   wire wr_cmd = wb_wr & (ADR_I == `VEC_OFS_CMD) & SEL_I[0];
   wire wr_stat = wb_wr & (ADR_I == `VEC_OFS_STAT) & SEL_I[0];
   wire busy = (state_q != S_IDLE) | seq_act_q;

   wire c_asel = ctrl_q[`VEC_CTRL_ASEL];
   wire c_rd = ctrl_q[`VEC_CTRL_RD];
   wire [1:0] c_cnt = ctrl_q[`VEC_CTRL_CNT_LO +: 2];
   wire [7:0] c_sub = ctrl_q[`VEC_CTRL_SUB_LO +: 8];
   wire [1:0] c_mode = ctrl_q[`VEC_CTRL_MODE_LO +: 2];
   wire [2:0] c_en = ctrl_q[`VEC_CTRL_EN_LO +: 3];
   wire c_csel = ctrl_q[`VEC_CTRL_CSEL];
   wire [7:0] c_fmt = ctrl_q[`VEC_CTRL_FMT_LO +: 8];

   // bursts may not straddle the split point nor touch the test area
   wire [8:0] last_sub = {1'b0, c_sub} + {7'd0, c_cnt};
   wire bad_burst = (c_cnt != 2'd0) &&
      (({1'b0, c_sub} <= `VEC_SUB_SPLIT_LO && last_sub > `VEC_SUB_SPLIT_LO) ||
       last_sub >= `VEC_SUB_TEST_BASE);
   wire want_xfer = wr_cmd & DAT_I[`VEC_CMD_XFER];
   wire want_sw = wr_cmd & DAT_I[`VEC_CMD_SWITCH];
   wire go_xfer = want_xfer & ~want_sw & ~busy & ~bad_burst;
   wire go_sw = want_sw & ~want_xfer & ~busy & (c_mode != `VEC_MODE_RESERVED);
   wire refuse = (want_xfer | want_sw) & ~go_xfer & ~go_sw;

   // ----------------------------------------------------------------
   // mode switch step table
   // ----------------------------------------------------------------
   // converters off, PLL off, new mode, PLL per mode, datapath reset low,
   // hold, reset release, settle, converters on; black burst and pixel
   // clock are outside this block and stay the caller's duty
   wire [7:0] dac_off = {2'b00, ctrl_q[`VEC_CTRL_OUTPUT_LEVEL_SELECT], 1'b1, c_csel, 3'b000};
   always @* begin
      seq_sub = `VEC_SUB_DAC;
      seq_data = dac_off;
      seq_wait = 2'd0;
      case (seq_q)
         4'd0: seq_data = dac_off;
         4'd1: begin
            seq_sub = `VEC_SUB_POWER_DOWN;
            seq_data = 8'h00;
         end
         4'd2: begin
            seq_sub = `VEC_SUB_FORMAT;
            seq_data = {c_fmt[7:4], c_mode, c_fmt[1:0]};
         end
         4'd3: begin
            seq_sub = `VEC_SUB_POWER_DOWN;
            // component needs the doubling PLL, the converter mode must not run it
            seq_data = (c_mode == `VEC_MODE_COMPONENT) ? 8'h04 : 8'h00;
         end
         4'd4: seq_data = {dac_off[7:5], 1'b0, dac_off[3:0]};
         4'd5: seq_wait = 2'd1;
         4'd6: seq_data = dac_off;
         4'd7: seq_wait = 2'd2;
         4'd8: seq_data = {dac_off[7:3], c_csel ? {2'b00, c_en[0]} : c_en};
         default: seq_wait = 2'd0;
      endcase
   end

   // ----------------------------------------------------------------
   // bit timing and pin targets
   // ----------------------------------------------------------------
   wire rx = (phase_q == P_RD);
   wire last_rx = (idx_q == cnt_q);
   wire in_sym = (state_q == S_START) | (state_q == S_BIT) | (state_q == S_STOP);
   // a released clock that the far end still holds low stretches the quarter
   wire stall = in_sym & ~SCL_OE_O & ~scl_s;
   wire tick_end = in_sym & (tick_q == QTR_LAST) & ~stall;
   wire sym_end = tick_end & (qtr_q == 2'd3);
   wire [1:0] nxt_idx = (phase_q == P_WD) ? idx_q + 2'd1 : idx_q;
   wire [7:0] wd_byte = seq_act_q ? seq_data : data_q[{nxt_idx, 3'b000} +: 8];
   wire [7:0] addr_w = {`VEC_DEV_ADDR_HI, c_asel, 1'b0};

   // enables high pull the line low
   always @* begin
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
      case (state_q)
         S_START: begin
            if (phase_q == P_AR) begin
               // repeated start: clock low first so the far end lets data rise
               scl_oe_d = ~qtr_q[1];
               sda_oe_d = (qtr_q == 2'd3);
            end else begin
               scl_oe_d = (qtr_q == 2'd3);
               sda_oe_d = qtr_q[1];
            end
         end
         S_BIT: begin
            scl_oe_d = ~qtr_q[1];
            if (bit_q == 4'd8)
               sda_oe_d = rx & ~last_rx;
            else
               sda_oe_d = ~rx & ~shreg_q[7];
         end
         S_STOP: begin
            scl_oe_d = ~qtr_q[1];
            sda_oe_d = (qtr_q != 2'd3);
         end
         default: begin
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
         end
      endcase
      // data waits a quarter after the clock falls, so it never moves with it
      if ((state_q == S_BIT || state_q == S_STOP) && qtr_q == 2'd0)
         sda_oe_d = SDA_OE_O;
   end

   // ----------------------------------------------------------------
   // transfer engine and mode switch sequencer
   // ----------------------------------------------------------------
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         state_q <= S_IDLE;
         phase_q <= P_AW;
         qtr_q <= 2'd0;
         tick_q <= 7'd0;
         bit_q <= 4'd0;
         shreg_q <= 8'h00;
         idx_q <= 2'd0;
         cnt_q <= 2'd0;
         sub_q <= 8'h00;
         rd_q <= 1'b0;
         nack_seen_q <= 1'b0;
         seq_act_q <= 1'b0;
         seq_q <= 4'd0;
         wait_q <= 22'd0;
         ev_nack_q <= 1'b0;
         ev_done_q <= 1'b0;
         ev_rd_q <= 1'b0;
         rd_idx_q <= 2'd0;
         rbyte_q <= 8'h00;
      end else begin
         ev_nack_q <= 1'b0;
         ev_done_q <= 1'b0;
         ev_rd_q <= 1'b0;
         if (in_sym) begin
            tick_q <= tick_end ? 7'd0 : (stall ? tick_q : tick_q + 7'd1);
            if (tick_end)
               qtr_q <= qtr_q + 2'd1;
         end
         case (state_q)
            S_IDLE: begin
               qtr_q <= 2'd0;
               tick_q <= 7'd0;
               bit_q <= 4'd0;
               idx_q <= 2'd0;
               phase_q <= P_AW;
               shreg_q <= addr_w;
               nack_seen_q <= 1'b0;
               if (go_xfer) begin
                  rd_q <= c_rd;
                  cnt_q <= c_cnt;
                  sub_q <= c_sub;
                  state_q <= S_START;
               end else if (go_sw) begin
                  seq_act_q <= 1'b1;
                  seq_q <= 4'd0;
               end else if (seq_act_q) begin
                  if (seq_q == SEQ_END) begin
                     seq_act_q <= 1'b0;
                  end else if (seq_wait != 2'd0) begin
                     wait_q <= (seq_wait == 2'd1) ? RST_HOLD_LAST : DAC_WAIT_LAST;
                     state_q <= S_WAIT;
                  end else begin
                     rd_q <= 1'b0;
                     cnt_q <= 2'd0;
                     sub_q <= seq_sub;
                     state_q <= S_START;
                  end
               end
            end
            S_START: begin
               if (sym_end)
                  state_q <= S_BIT;
            end
            S_BIT: begin
               if (sym_end && bit_q != 4'd8) begin
                  shreg_q <= {shreg_q[6:0], rx ? sda_s : 1'b0};
                  bit_q <= bit_q + 4'd1;
               end else if (sym_end) begin
                  bit_q <= 4'd0;
                  if (!rx && sda_s) begin
                     // refused byte: end the frame at once
                     state_q <= S_STOP;
                     nack_seen_q <= 1'b1;
                     ev_nack_q <= 1'b1;
                  end else begin
                     case (phase_q)
                        P_AW: begin
                           shreg_q <= sub_q;
                           phase_q <= P_SUB;
                        end
                        P_SUB: begin
                           if (rd_q) begin
                              shreg_q <= addr_w | 8'h01;
                              phase_q <= P_AR;
                              state_q <= S_START;
                           end else begin
                              shreg_q <= wd_byte;
                              phase_q <= P_WD;
                           end
                        end
                        P_WD: begin
                           if (idx_q == cnt_q) begin
                              state_q <= S_STOP;
                           end else begin
                              shreg_q <= wd_byte;
                              idx_q <= idx_q + 2'd1;
                           end
                        end
                        P_AR: phase_q <= P_RD;
                        P_RD: begin
                           ev_rd_q <= 1'b1;
                           rd_idx_q <= idx_q;
                           rbyte_q <= shreg_q;
                           if (last_rx)
                              state_q <= S_STOP;
                           else
                              idx_q <= idx_q + 2'd1;
                        end
                        default: state_q <= S_STOP;
                     endcase
                  end
               end
            end
            S_STOP: begin
               if (sym_end) begin
                  state_q <= S_IDLE;
                  ev_done_q <= 1'b1;
                  if (seq_act_q) begin
                     seq_act_q <= ~nack_seen_q;
                     seq_q <= seq_q + 4'd1;
                  end
               end
            end
            S_WAIT: begin
               if (wait_q == 22'd0) begin
                  seq_q <= seq_q + 4'd1;
                  state_q <= S_IDLE;
               end else begin
                  wait_q <= wait_q - 22'd1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // software registers, status and bus answer
   // ----------------------------------------------------------------
   // sticky flags: a new event in the clearing cycle survives
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         ctrl_q <= `VEC_CTRL_RESET;
         data_q <= `VEC_DATA_RESET;
         nack_q <= 1'b0;
         refused_q <= 1'b0;
         done_q <= 1'b0;
         ACK_O <= 1'b0;
         DAT_O <= 32'h0000_0000;
      end else begin
         ACK_O <= wb_hit;
         if (wr_ctrl)
            ctrl_q <= (ctrl_q & ~wmask) | (DAT_I & wmask);
         if (ev_rd_q)
            data_q[{rd_idx_q, 3'b000} +: 8] <= rbyte_q;
         else if (wr_data)
            data_q <= (data_q & ~wmask) | (DAT_I & wmask);
         nack_q <= ev_nack_q | (nack_q & ~(wr_stat & DAT_I[`VEC_STAT_NACK]));
         refused_q <= refuse | (refused_q & ~(wr_stat & DAT_I[`VEC_STAT_REFUSED]));
         done_q <= ev_done_q | (done_q & ~(wr_stat & DAT_I[`VEC_STAT_DONE]));
         DAT_O <= 32'h0000_0000;
         if (wb_hit && !WE_I) begin
            case (ADR_I)
               `VEC_OFS_CTRL: DAT_O <= ctrl_q;
               `VEC_OFS_DATA: DAT_O <= data_q;
               `VEC_OFS_STAT: DAT_O <= {24'h00_0000, seq_q, done_q, refused_q, nack_q, busy};
               default: DAT_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   // pins: open drain lines only ever pull low
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         SCL_O <= 1'b0;
         SDA_O <= 1'b0;
         SCL_OE_O <= 1'b0;
         SDA_OE_O <= 1'b0;
         BUS_ADDRESS_SELECT_PIN_O <= 1'b0;
         POWER_DOWN_PIN_N_O <= 1'b0;
      end else begin
         SCL_O <= 1'b0;
         SDA_O <= 1'b0;
         SCL_OE_O <= scl_oe_d;
         SDA_OE_O <= sda_oe_d;
         BUS_ADDRESS_SELECT_PIN_O <= c_asel;
         // holding the pin low returns the device to composite defaults
         POWER_DOWN_PIN_N_O <= ~ctrl_q[`VEC_CTRL_PDN];
      end
   end
endmodule // vec_ctrl_host

// >>> test/vec_ctrl_monitor.sv
// checker for the video encoder control host ports
`timescale 1ns/10ps
module vec_ctrl_monitor #(
   parameter [21:0] DAC_WAIT_CYC = 22'd200
) (
   // system
   input wire CLK_I,
   input wire SRST_I,
   // wishbone
   input wire CYC_I,
   input wire STB_I,
   input wire WE_I,
   input wire [7:0] ADR_I,
   input wire [3:0] SEL_I,
   input wire [31:0] DAT_I,
   input wire [31:0] DAT_O,
   input wire ACK_O,
   // serial bus and device pins
   input wire SCL_I,
   input wire SCL_O,
   input wire SCL_OE_O,
   input wire SDA_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   input wire BUS_ADDRESS_SELECT_PIN_O,
   input wire POWER_DOWN_PIN_N_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);
   logic [15:0] lo_q;
   logic [15:0] hi_q;
   // time the clock line spends low and high; a short phase breaks slow devices
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         lo_q <= 16'h0000;
         hi_q <= 16'h0000;
      end else begin
         lo_q <= SCL_I ? 16'h0000 : lo_q + 16'h0001;
         hi_q <= SCL_I ? hi_q + 16'h0001 : 16'h0000;
      end
   end
   sequence s_take;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence s_ctrl_wr;
      s_take ##0 (WE_I && ADR_I == 8'h00 && SEL_I[0]);
   endsequence
   sequence s_start;
      SCL_I && $fell(SDA_I);
   endsequence
   AST_ACK_NEXT: assert property (s_take |=> ACK_O) else $error("ack missing");
   AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
   AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0000_0000) else $error("data not idle");
   AST_PIN_LOW: assert property (!SCL_O && !SDA_O) else $error("open drain level high");
   AST_SEL_PIN: assert property (s_ctrl_wr |=> ##1 BUS_ADDRESS_SELECT_PIN_O == $past(DAT_I[0], 2))
      else $error("select pin wrong");
   AST_PDN_PIN: assert property (s_ctrl_wr |=> ##1 POWER_DOWN_PIN_N_O == !$past(DAT_I[1], 2))
      else $error("power-down pin wrong");
   AST_START_HOLD: assert property (s_start |-> ##[60:80] $fell(SCL_I)) else $error("start hold");
   AST_SCL_LOW_MIN: assert property ($rose(SCL_I) |-> lo_q >= 16'd130) else $error("low too short");
   AST_SCL_HIGH_MIN: assert property ($fell(SCL_I) |-> hi_q >= 16'd60) else $error("high too short");
endmodule // vec_ctrl_monitor

bind vec_ctrl_host vec_ctrl_monitor #(.DAC_WAIT_CYC(DAC_WAIT_CYC)) mon (
   .CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
   .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O), .BUS_ADDRESS_SELECT_PIN_O(BUS_ADDRESS_SELECT_PIN_O),
   .POWER_DOWN_PIN_N_O(POWER_DOWN_PIN_N_O));

// >>> test/vec_dev_model.sv
// behavioural model of the encoder's serial control port and mode registers
`timescale 1ns/10ps
module vec_dev_model (
   // bus lines as seen on the wire
   input wire scl_i,
   input wire sda_i,
   // strap and power pins
   input wire sel_i,
   input wire pdn_n_i,
   // high pulls the data line low
   output logic sda_pull_o
);
   logic [7:0] regs [0:127];
   logic [7:0] sh;
   logic [7:0] sub;
   logic act;
   logic rd;
   logic tx;
   logic mack;
   int bitc;
   int st;
   realtime t_lo;
   realtime hold;
   // block power follows the mode field; no pixel clock is needed anywhere
   wire [1:0] mode = regs[11][3:2];
   wire comp_on = mode == 2'b01;
   wire pll_on = regs[6][2];
   wire [2:0] dac_on = regs[13][2:0] & (regs[13][3] ? 3'b001 : 3'b111);
   initial begin
      sda_pull_o = 1'b0;
      act = 1'b0;
      hold = 0.0;
   end
   // power-down pin restores defaults and drops any transfer
   always @(negedge pdn_n_i) begin
      foreach (regs[i]) regs[i] = 8'h00;
      act = 1'b0;
      sda_pull_o = 1'b0;
   end
   // start or repeated start; the sub-address survives it
   always @(negedge sda_i) if (scl_i && pdn_n_i) begin
      act = 1'b1;
      bitc = 0;
      st = 0;
      tx = 1'b0;
      sda_pull_o = 1'b0;
   end
   // stop
   always @(posedge sda_i) if (scl_i) act = 1'b0;
   // shift in on the rising clock, master acknowledge on the ninth
   always @(posedge scl_i) if (act) begin
      if (bitc < 8 && !tx) sh = {sh[6:0], sda_i};
      if (bitc == 8) mack = !sda_i;
      bitc++;
   end
   // drive or release data only while the clock is low
   always @(negedge scl_i) if (act) begin
      sda_pull_o = 1'b0;
      if (bitc == 8 && !tx) begin
         if (st == 0) begin
            rd = sh[0];
            act = sh[7:1] == {6'h10, sel_i};
         end else if (st == 1) begin
            sub = sh;
         end else begin
            if (sub == 8'h0D && !sh[4]) t_lo = $realtime;
            if (sub == 8'h0D && sh[4] && !regs[13][4]) hold = $realtime - t_lo;
            regs[sub[6:0]] = sh;
            sub++;
         end
         sda_pull_o = act;
      end else if (bitc == 9) begin
         bitc = 0;
         if (st == 0) st = rd ? 3 : 1;
         else if (st == 1) st = 2;
         if (st == 3 && (!tx || mack)) begin
            tx = 1'b1;
            sh = regs[sub[6:0]];
            sub++;
            sda_pull_o = !sh[7];
         end else if (tx) begin
            act = 1'b0;
         end
      end else if (tx && bitc < 8) begin
         sda_pull_o = !sh[7 - bitc];
      end
   end
endmodule // vec_dev_model

// >>> test/tb_top.sv
// self-checking bench for the video encoder control host
`timescale 1ns/10ps
`define CHK(a, b) begin \
   comparisons++; \
   if ((a) !== (b)) begin \
      fail_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
   end \
end
module tb_top;
   logic clk, srst, cyc, stb, we, flip, ack, scl_oe, sda_oe, scl_o, sda_o, asel, pdn_n, pull;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, rdat;
   int fail_count = 0;
   int comparisons = 0;
   // open-drain lines with pull-ups
   wire scl_w = scl_oe ? 1'b0 : 1'b1;
   wire sda_w = (sda_oe | pull) ? 1'b0 : 1'b1;
   vec_ctrl_host #(.DAC_WAIT_CYC(22'd200)) dut (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc),
      .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack),
      .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .BUS_ADDRESS_SELECT_PIN_O(asel), .POWER_DOWN_PIN_N_O(pdn_n));
   // flip lets a scenario strap the device to the other address
   vec_dev_model dev (.scl_i(scl_w), .sda_i(sda_w), .sel_i(asel ^ flip), .pdn_n_i(pdn_n),
      .sda_pull_o(pull));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one classic cycle; read data is taken at the acknowledging edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // clear sticky flags, issue a command, wait until idle, check the flags
   task automatic run(input logic [31:0] c, input logic [3:0] exp_st);
      logic [31:0] q;
      int n;
      wb(1'b1, 8'h0C, 32'h0000_000F, q);
      wb(1'b1, 8'h08, c, q);
      n = 0;
      do begin
         wb(1'b0, 8'h0C, 32'h0000_0000, q);
         n++;
      end while (q[0] !== 1'b0 && n < 30000);
      `CHK(q[3:0], exp_st)
   endtask
   // a hang ends the run as a failure
   initial begin
      #2_000_000;
      fail_count++;
      complete_run();
   end
   initial begin
      logic [31:0] q;
      srst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      flip = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      dat = 32'h0000_0000;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      // defaults and an unmapped hole
      wb(1'b0, 8'h00, 32'h0, q);
      `CHK(q, 32'h0000_0000)
      wb(1'b1, 8'h10, 32'hFFFF_FFFF, q);
      wb(1'b0, 8'h10, 32'h0, q);
      `CHK(q, 32'h0000_0000)
      // two-byte burst ending right at the split, low strap level
      wb(1'b1, 8'h04, 32'h0000_BBAA, q);
      wb(1'b1, 8'h00, 32'h0000_3408, q);
      run(32'h1, 4'h8);
      `CHK({dev.regs[7'h35], dev.regs[7'h34]}, 16'hBBAA)
      // read back through a repeated start, high strap level
      wb(1'b1, 8'h04, 32'h0, q);
      wb(1'b1, 8'h00, 32'h0000_340D, q);
      run(32'h1, 4'h8);
      wb(1'b0, 8'h04, 32'h0, q);
      `CHK(q[15:0], 16'hBBAA)
      // bursts across the split or into the test area, and a double command
      wb(1'b1, 8'h00, 32'h0000_3509, q);
      run(32'h1, 4'h4);
      wb(1'b1, 8'h00, 32'h0000_3F09, q);
      run(32'h1, 4'h4);
      run(32'h3, 4'h4);
      // wrong strap level: no acknowledge, nothing stored
      flip <= 1'b1;
      wb(1'b1, 8'h04, 32'h0000_0055, q);
      wb(1'b1, 8'h00, 32'h0000_3401, q);
      run(32'h1, 4'hA);
      `CHK(dev.regs[7'h34], 8'hAA)
      flip <= 1'b0;
      // component mode with composite forced onto the first converter, then the reserved mode refused
      wb(1'b1, 8'h00, 32'hFF79_0001, q);
      run(32'h2, 4'h8);
      `CHK(dev.regs[7'h0B], 8'hF7)
      `CHK(dev.regs[7'h06], 8'h04)
      `CHK(dev.regs[7'h0D], 8'h19)
      `CHK(dev.hold >= 17000.0, 1'b1)
      wb(1'b1, 8'h00, 32'hFF7B_0001, q);
      run(32'h2, 4'h4);
      // power-down pulse returns the device to composite defaults
      wb(1'b1, 8'h00, 32'hFF79_0003, q);
      repeat (20) @(posedge clk);
      wb(1'b1, 8'h00, 32'hFF79_0001, q);
      `CHK(dev.regs[7'h0B], 8'h00)
      complete_run();
   end
endmodule // tb_top
